// *** hw/xcvr_defines.svh ***
// Named offsets, field positions and reset values of the registered transceiver.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef XCVR_DEFINES_SVH
`define XCVR_DEFINES_SVH

`define XCVR_DATA_W        8
`define XCVR_ADDR_W        8
`define XCVR_SYNC_STAGES   2

// Register byte offsets.
`define XCVR_CTRL_ADDR     8'h00
`define XCVR_STORE_A_ADDR  8'h04
`define XCVR_STORE_B_ADDR  8'h08
`define XCVR_STATUS_ADDR   8'h0c

// Control register fields.
`define XCVR_CTRL_OE_N     0
`define XCVR_CTRL_DIR      1
`define XCVR_CTRL_SAB      2
`define XCVR_CTRL_SBA      3
`define XCVR_CTRL_W        4
`define XCVR_CTRL_RESET    4'h1

// Status register fields.
`define XCVR_STAT_A_VALID  0
`define XCVR_STAT_B_VALID  1
`define XCVR_STAT_MODE_LO  2
`define XCVR_STAT_MODE_HI  3

`define XCVR_STORE_RESET   8'h00
`define XCVR_RDATA_ZERO    32'h0000_0000

`endif

// *** hw/xcvr_pkg.sv ***
// Types shared by the registered transceiver modules.
// Assumes the defines header is on the include path.
`include "xcvr_defines.svh"

package xcvr_pkg;
   typedef logic [`XCVR_DATA_W-1:0] data_t;
   typedef logic [`XCVR_ADDR_W-1:0] addr_t;
   typedef logic [31:0]             word_t;

   typedef enum logic [1:0] {
      MODE_ISOLATE,
      MODE_DRIVE_B,
      MODE_DRIVE_A
   } drive_mode_e;
endpackage

// *** hw/bit_sync.sv ***
// Two-flop synchroniser for a vector of independent pin levels.
// Assumes each bit is an unrelated level; no word coherence is promised.
`timescale 1ns/1ps

module bit_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_reset,
   // Levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge i_sys_clk or posedge i_reset) begin
            if (i_reset) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= i_async[g];
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign o_sync = sync_r;
endmodule

// *** hw/registered_xcvr.sv ***
// Octal registered bus transceiver between pin groups A and B, with storage
// registers captured on the rising edges of two pin clocks and a small
// register port for control and readback.
// Assumes all pin inputs are asynchronous to i_sys_clk and that the board
// resolves each bus wire from the output enables.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "xcvr_defines.svh"

//Contract
// - Capture A into the A store and B into the B store on clock rises.
// - Enable high: drive neither port, yet both stores still load.
// - Enable low: direction high drives B from A, low drives A from B.
// - B output is live A when select low, stored A when high, uninverted.
// - A output is live B when select low, stored B when high, uninverted.
// - Capturing during live transfer leaves the live output path undisturbed.
// - With stored source selected, a capture shows the new value on output.
// - A store holds its contents whenever its own clock does not rise.
// - Capture clocks are never gated by enable, direction or selects.
module registered_xcvr
   import xcvr_pkg::*;
(
   // Clock and reset
   input  wire logic            i_sys_clk,
   input  wire logic            i_reset,
   // Register port
   input  xcvr_pkg::addr_t      i_addr,
   input  xcvr_pkg::word_t      i_wdata,
   input  wire logic            i_wr,
   input  wire logic            i_rd,
   output xcvr_pkg::word_t      o_rdata,
   // Capture clock pins
   input  wire logic            i_clk_a_to_b,
   input  wire logic            i_clk_b_to_a,
   // Port A pins
   input  xcvr_pkg::data_t      i_port_a,
   output xcvr_pkg::data_t      o_port_a,
   output logic                 o_port_a_oe,
   // Port B pins
   input  xcvr_pkg::data_t      i_port_b,
   output xcvr_pkg::data_t      o_port_b,
   output logic                 o_port_b_oe
);
   import xcvr_pkg::*;

   localparam int SYNC_W = 2 * `XCVR_DATA_W + 2;

   // Synchronised pin levels.
   logic [SYNC_W-1:0] sync_vec;
   data_t             a_live;
   data_t             b_live;
   logic              clk_ab_s;
   logic              clk_ba_s;

   bit_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_async   ({i_clk_b_to_a, i_clk_a_to_b, i_port_b, i_port_a}),
      .o_sync    (sync_vec)
   );

   assign a_live   = sync_vec[`XCVR_DATA_W-1:0];
   assign b_live   = sync_vec[2*`XCVR_DATA_W-1:`XCVR_DATA_W];
   assign clk_ab_s = sync_vec[2*`XCVR_DATA_W];
   assign clk_ba_s = sync_vec[2*`XCVR_DATA_W+1];

   // Control register and its decoded fields.
   logic [`XCVR_CTRL_W-1:0] ctrl_r;
   logic [`XCVR_CTRL_W-1:0] ctrl_nxt;
   logic                    output_enable_n;
   logic                    direction;
   logic                    a_to_b_source_select;
   logic                    b_to_a_source_select;

   assign output_enable_n      = ctrl_r[`XCVR_CTRL_OE_N];
   assign direction            = ctrl_r[`XCVR_CTRL_DIR];
   assign a_to_b_source_select = ctrl_r[`XCVR_CTRL_SAB];
   assign b_to_a_source_select = ctrl_r[`XCVR_CTRL_SBA];

   // Storage state.
   logic  clk_ab_prev_r;
   logic  clk_ab_prev_nxt;
   logic  clk_ba_prev_r;
   logic  clk_ba_prev_nxt;
   data_t port_a_store_r;
   data_t port_a_store_nxt;
   data_t port_b_store_r;
   data_t port_b_store_nxt;
   logic  a_valid_r;
   logic  a_valid_nxt;
   logic  b_valid_r;
   logic  b_valid_nxt;
   logic  cap_a;
   logic  cap_b;

   // Output state.
   drive_mode_e mode;
   data_t       port_a_r;
   data_t       port_a_nxt;
   data_t       port_b_r;
   data_t       port_b_nxt;
   logic        port_a_oe_r;
   logic        port_a_oe_nxt;
   logic        port_b_oe_r;
   logic        port_b_oe_nxt;
   word_t       rdata_r;
   word_t       rdata_nxt;

   // Edge detection runs on the second synchroniser stage only.
   always_comb begin
      clk_ab_prev_nxt  = clk_ab_s;
      clk_ba_prev_nxt  = clk_ba_s;
      cap_a            = clk_ab_s & ~clk_ab_prev_r;
      cap_b            = clk_ba_s & ~clk_ba_prev_r;
      port_a_store_nxt = port_a_store_r;
      port_b_store_nxt = port_b_store_r;
      a_valid_nxt      = a_valid_r;
      b_valid_nxt      = b_valid_r;
      if (cap_a) begin
         port_a_store_nxt = a_live;
         a_valid_nxt      = 1'b1;
      end
      if (cap_b) begin
         port_b_store_nxt = b_live;
         b_valid_nxt      = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         clk_ab_prev_r  <= 1'b0;
         clk_ba_prev_r  <= 1'b0;
         port_a_store_r <= `XCVR_STORE_RESET;
         port_b_store_r <= `XCVR_STORE_RESET;
         a_valid_r      <= 1'b0;
         b_valid_r      <= 1'b0;
      end else begin
         clk_ab_prev_r  <= clk_ab_prev_nxt;
         clk_ba_prev_r  <= clk_ba_prev_nxt;
         port_a_store_r <= port_a_store_nxt;
         port_b_store_r <= port_b_store_nxt;
         a_valid_r      <= a_valid_nxt;
         b_valid_r      <= b_valid_nxt;
      end
   end

   // Outputs use the next store value, so a capture and its appearance on
   // the driven port happen on the same edge instead of one cycle apart.
   always_comb begin
      if (output_enable_n) begin
         mode = MODE_ISOLATE;
      end else if (direction) begin
         mode = MODE_DRIVE_B;
      end else begin
         mode = MODE_DRIVE_A;
      end
      port_b_nxt    = a_to_b_source_select ? port_a_store_nxt : a_live;
      port_a_nxt    = b_to_a_source_select ? port_b_store_nxt : b_live;
      port_b_oe_nxt = (mode == MODE_DRIVE_B);
      port_a_oe_nxt = (mode == MODE_DRIVE_A);
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         port_a_r    <= `XCVR_STORE_RESET;
         port_b_r    <= `XCVR_STORE_RESET;
         port_a_oe_r <= 1'b0;
         port_b_oe_r <= 1'b0;
      end else begin
         port_a_r    <= port_a_nxt;
         port_b_r    <= port_b_nxt;
         port_a_oe_r <= port_a_oe_nxt;
         port_b_oe_r <= port_b_oe_nxt;
      end
   end

   // Register port: one-cycle writes, read data in the following cycle only.
   always_comb begin
      ctrl_nxt  = ctrl_r;
      rdata_nxt = `XCVR_RDATA_ZERO;
      if (i_wr && i_addr == `XCVR_CTRL_ADDR) begin
         ctrl_nxt = i_wdata[`XCVR_CTRL_W-1:0];
      end
      if (i_rd) begin
         unique case (i_addr)
            `XCVR_CTRL_ADDR: begin
               rdata_nxt[`XCVR_CTRL_W-1:0] = ctrl_r;
            end
            `XCVR_STORE_A_ADDR: begin
               rdata_nxt[`XCVR_DATA_W-1:0] = port_a_store_r;
            end
            `XCVR_STORE_B_ADDR: begin
               rdata_nxt[`XCVR_DATA_W-1:0] = port_b_store_r;
            end
            `XCVR_STATUS_ADDR: begin
               rdata_nxt[`XCVR_STAT_A_VALID] = a_valid_r;
               rdata_nxt[`XCVR_STAT_B_VALID] = b_valid_r;
               rdata_nxt[`XCVR_STAT_MODE_HI:`XCVR_STAT_MODE_LO] = mode;
            end
            default: begin
               rdata_nxt = `XCVR_RDATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_r  <= `XCVR_CTRL_RESET;
         rdata_r <= `XCVR_RDATA_ZERO;
      end else begin
         ctrl_r  <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_port_a    = port_a_r;
   assign o_port_b    = port_b_r;
   assign o_port_a_oe = port_a_oe_r;
   assign o_port_b_oe = port_b_oe_r;
   assign o_rdata     = rdata_r;
endmodule

// *** sim/registered_xcvr_assertions.sv ***
// Checker for the registered transceiver, bound onto its top module.
// Assumes control changes only through writes on the register port.
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module registered_xcvr_assertions
   import xcvr_pkg::*;
(
   // Clock, reset and register writes
   input wire logic       i_sys_clk,
   input wire logic       i_reset,
   input xcvr_pkg::addr_t i_addr,
   input xcvr_pkg::word_t i_wdata,
   input wire logic       i_wr,
   // Pins
   input wire logic       i_clk_a_to_b,
   input xcvr_pkg::data_t i_port_a,
   input xcvr_pkg::data_t i_port_b,
   input xcvr_pkg::data_t o_port_a,
   input wire logic       o_port_a_oe,
   input xcvr_pkg::data_t o_port_b,
   input wire logic       o_port_b_oe
);
   logic [3:0] ctrl_r, ctrl_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic       drv_a, drv_b;
   // Mode checks wait until a new control value has passed the output flops.
   assign drv_b = cnt_r[2] && ctrl_r[1:0] == 2'b10;
   assign drv_a = cnt_r[2] && ctrl_r[1:0] == 2'b00;
   always_comb begin
      ctrl_nxt = ctrl_r;
      cnt_nxt  = cnt_r[2] ? cnt_r : cnt_r + 3'h1;
      if (i_wr && i_addr == `XCVR_CTRL_ADDR) begin
         ctrl_nxt = i_wdata[3:0];
         cnt_nxt  = 3'h0;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_r <= `XCVR_CTRL_RESET;
         cnt_r  <= 3'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cnt_r  <= cnt_nxt;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_rise_ab; !i_clk_a_to_b ##1 i_clk_a_to_b; endsequence
   sequence s_quiet_ab; $stable(i_clk_a_to_b) [*4]; endsequence
   property p_oe_excl; !(o_port_a_oe && o_port_b_oe); endproperty
   a_oe_excl: assert property (p_oe_excl) else $error("both ports driven");
   property p_isolate; cnt_r[2] && ctrl_r[0] |-> !o_port_a_oe && !o_port_b_oe; endproperty
   a_isolate: assert property (p_isolate) else $error("driven while isolated");
   property p_drive_b; drv_b |-> o_port_b_oe && !o_port_a_oe; endproperty
   a_drive_b: assert property (p_drive_b) else $error("port b not driven");
   property p_drive_a; drv_a |-> o_port_a_oe && !o_port_b_oe; endproperty
   a_drive_a: assert property (p_drive_a) else $error("port a not driven");
   property p_live_b; drv_b && !ctrl_r[2] |-> o_port_b == $past(i_port_a, 3); endproperty
   a_live_b: assert property (p_live_b) else $error("live b wrong");
   property p_live_a; drv_a && !ctrl_r[3] |-> o_port_a == $past(i_port_b, 3); endproperty
   a_live_a: assert property (p_live_a) else $error("live a wrong");
   property p_store_b;
      s_rise_ab ##0 (drv_b && ctrl_r[2]) |-> ##3 o_port_b == $past(i_port_a, 3);
   endproperty
   a_store_b: assert property (p_store_b) else $error("stored b wrong");
   property p_hold_b; s_quiet_ab ##0 (drv_b && ctrl_r[2]) |-> $stable(o_port_b); endproperty
   a_hold_b: assert property (p_hold_b) else $error("store a moved");
endmodule

// *** sim/far_bus.sv ***
// Outside bus logic on ports A and B.
// Assumes the bench supplies the values that each side offers.
`timescale 1ns/1ps
module far_bus
   import xcvr_pkg::*;
(
   // Values the outside logic offers
   input xcvr_pkg::data_t  i_val_a,
   input xcvr_pkg::data_t  i_val_b,
   // Device drive and its enables
   input xcvr_pkg::data_t  i_dev_a,
   input wire logic        i_dev_a_oe,
   input xcvr_pkg::data_t  i_dev_b,
   input wire logic        i_dev_b_oe,
   // Resolved bus levels
   output xcvr_pkg::data_t o_wire_a,
   output xcvr_pkg::data_t o_wire_b
);
   // Backing off while the device drives keeps one driver on each bus.
   assign o_wire_a = i_dev_a_oe ? i_dev_a : i_val_a;
   assign o_wire_b = i_dev_b_oe ? i_dev_b : i_val_b;
endmodule

// *** sim/tb_registered_xcvr.sv ***
// Self-checking bench for the registered transceiver.
// Assumes reads answer one cycle late and pins pass a two-flop sync.
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module tb_registered_xcvr;
   import xcvr_pkg::*;
   logic  i_sys_clk, i_reset, i_wr, i_rd, i_clk_a_to_b, i_clk_b_to_a;
   logic  o_port_a_oe, o_port_b_oe;
   logic  rd_d = 1'b0;
   addr_t i_addr;
   word_t i_wdata, o_rdata;
   data_t i_port_a, i_port_b, o_port_a, o_port_b, va, vb, sa, sb;
   word_t q[$];
   int    num_errors = 0, num_checks = 0, cyc = 0;
   registered_xcvr i_registered_xcvr (
      .i_sys_clk    (i_sys_clk),
      .i_reset      (i_reset),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata),
      .i_clk_a_to_b (i_clk_a_to_b),
      .i_clk_b_to_a (i_clk_b_to_a),
      .i_port_a     (i_port_a),
      .o_port_a     (o_port_a),
      .o_port_a_oe  (o_port_a_oe),
      .i_port_b     (i_port_b),
      .o_port_b     (o_port_b),
      .o_port_b_oe  (o_port_b_oe)
   );
   far_bus i_far_bus (.i_val_a(va), .i_val_b(vb), .i_dev_a(o_port_a),
      .i_dev_a_oe(o_port_a_oe), .i_dev_b(o_port_b), .i_dev_b_oe(o_port_b_oe),
      .o_wire_a(i_port_a), .o_wire_b(i_port_b));
   task automatic close_out();
      if (num_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string n, word_t e, word_t g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(addr_t a, word_t d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic rd_reg(addr_t a, word_t e);
      q.push_back(e);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic pulse(logic a, logic b);
      if (a) sa = i_port_a;
      if (b) sb = i_port_b;
      i_clk_a_to_b <= a;
      i_clk_b_to_a <= b;
      repeat (4) @(posedge i_sys_clk);
      i_clk_a_to_b <= 1'b0;
      i_clk_b_to_a <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
   endtask
   function automatic logic [1:0] mode_of(int c);
      return c[0] ? 2'b00 : (c[1] ? 2'b01 : 2'b10);
   endfunction
   task automatic ports(int c);
      logic [1:0] m;
      m = mode_of(c);
      chk("ports", {14'h0, m, m[0] ? (c[2] ? sa : va) : 8'h0, m[1] ? (c[3] ? sb : vb) : 8'h0},
         {14'h0, o_port_a_oe, o_port_b_oe, o_port_b_oe ? o_port_b : 8'h0,
         o_port_a_oe ? o_port_a : 8'h0});
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   // Read data stand only in the cycle after the strobe, so look exactly there.
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (rd_d) chk("rdata", q.pop_front(), o_rdata);
      rd_d <= i_rd;
      // A hang ends here as a failure; the run should need well under a thousand cycles.
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'h3731));
      {i_reset, i_wr, i_rd, i_clk_a_to_b, i_clk_b_to_a} = 5'h10;
      {i_addr, i_wdata, va, vb} = '0;
      repeat (20) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      @(posedge i_sys_clk);
      rd_reg(`XCVR_STATUS_ADDR, 32'h0);
      rd_reg(`XCVR_CTRL_ADDR, 32'h1);
      rd_reg(8'h10, 32'h0);
      va <= 8'($urandom);
      vb <= 8'($urandom);
      repeat (4) @(posedge i_sys_clk);
      pulse(1'b1, 1'b1);
      for (int c = 0; c < 16; c++) begin
         wr_reg(`XCVR_CTRL_ADDR, 32'(c));
         va <= 8'($urandom);
         vb <= 8'($urandom);
         repeat (6) @(posedge i_sys_clk);
         ports(c);
         pulse(c[1] | c[0], !c[1] | c[0]);
         ports(c);
         rd_reg(`XCVR_STORE_A_ADDR, {24'h0, sa});
         rd_reg(`XCVR_STORE_B_ADDR, {24'h0, sb});
         va <= 8'($urandom);
         vb <= 8'($urandom);
         repeat (6) @(posedge i_sys_clk);
         ports(c);
         rd_reg(`XCVR_STATUS_ADDR, {28'h0, mode_of(c), 2'b11});
         rd_reg(`XCVR_STORE_A_ADDR, {24'h0, sa});
      end
      // Let the checker take the last read data before the run ends.
      repeat (2) @(posedge i_sys_clk);
      close_out();
   end
endmodule
bind registered_xcvr registered_xcvr_assertions i_registered_xcvr_assertions (
   .i_sys_clk    (i_sys_clk),
   .i_reset      (i_reset),
   .i_addr       (i_addr),
   .i_wdata      (i_wdata),
   .i_wr         (i_wr),
   .i_clk_a_to_b (i_clk_a_to_b),
   .i_port_a     (i_port_a),
   .i_port_b     (i_port_b),
   .o_port_a     (o_port_a),
   .o_port_a_oe  (o_port_a_oe),
   .o_port_b     (o_port_b),
   .o_port_b_oe  (o_port_b_oe)
);
